// ===== rtl/odc_map.svh
/*
 * Constants of the one-wire dimming control block: timing, register map,
 * field positions and reset values.
 * Assumes a 10 MHz ref_clk; every cycle count derives from the time figure.
 */
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// ----------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------
`define ODC_CLK_NS 100
`define ODC_EN_TO_US 2500
`define ODC_PWM_TO_US 20000
`define ODC_SS_US 5000
`define ODC_DET_DLY_US 100
`define ODC_DET_LO_US 260
`define ODC_DET_WIN_US 1000
`define ODC_BIT_MAX_US 360
`define ODC_ACK_VAL_US 2
`define ODC_ACK_LEN_US 512
// Least times round up, longest times round down
`define ODC_UP(t) (((t) * 1000 + `ODC_CLK_NS - 1) / `ODC_CLK_NS)
`define ODC_DN(t) (((t) * 1000) / `ODC_CLK_NS)
`define ODC_EN_TO_CYC `ODC_UP(`ODC_EN_TO_US)
`define ODC_PWM_TO_CYC `ODC_UP(`ODC_PWM_TO_US)
`define ODC_SS_CYC `ODC_DN(`ODC_SS_US)
`define ODC_DET_DLY_CYC `ODC_UP(`ODC_DET_DLY_US)
`define ODC_DET_LO_CYC `ODC_UP(`ODC_DET_LO_US)
`define ODC_DET_WIN_CYC `ODC_DN(`ODC_DET_WIN_US)
`define ODC_BIT_MAX_CYC `ODC_DN(`ODC_BIT_MAX_US)
`define ODC_ACK_VAL_CYC `ODC_DN(`ODC_ACK_VAL_US)
`define ODC_ACK_LEN_CYC `ODC_DN(`ODC_ACK_LEN_US)

// ----------------------------------------------------------------
// Command layout and register map
// ----------------------------------------------------------------
`define ODC_CMD_BITS 24
`define ODC_CODE_DEF 9'h1FF
`define ODC_ACK_BIT 10
`define ODC_REG_STATUS 2'h0
`define ODC_REG_CTRL 2'h1
`define ODC_CTRL_RST 16'h0001
`endif

// ===== rtl/odc_pkg.sv
/*
 * Types of the one-wire dimming control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package odc_pkg;
    // Operating state of the device
    typedef enum logic [1:0] {
        ODC_SHUT = 2'b00,
        ODC_DETECT = 2'b01,
        ODC_ONEWIRE = 2'b10,
        ODC_PWM = 2'b11
    } odc_state_t;
    // Acknowledge sequencer
    typedef enum logic [1:0] {
        ODC_ACK_IDLE = 2'b00,
        ODC_ACK_WAIT = 2'b01,
        ODC_ACK_PULL = 2'b10
    } odc_ack_t;
endpackage

// ===== rtl/odc_top.sv
/*
 * Digital control of a dual-channel backlight driver: interface selection,
 * shutdown timeouts, soft-start limit timer and the one-wire receiver.
 * Assumes ref_clk at 10 MHz and pin inputs synchronous to it; the enable
 * line is open drain outside, resolved from line_pull_oe by the bench.
 */
`include "odc_map.svh"

module odc_top #(
    parameter int P_EN_TO_CYC = `ODC_EN_TO_CYC,
    parameter int P_PWM_TO_CYC = `ODC_PWM_TO_CYC,
    parameter int P_SS_CYC = `ODC_SS_CYC,
    parameter int P_DET_WIN_CYC = `ODC_DET_WIN_CYC,
    parameter int P_ACK_LEN_CYC = `ODC_ACK_LEN_CYC,
    parameter logic [7:0] P_DEV_ADDR = 8'h5A // Value is arbitrary
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic undervoltage_lockout_ok,
    input wire logic en_line_i,
    input wire logic pwm_i,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic line_pull_o,
    output logic line_pull_oe,
    output logic dev_on,
    output logic onewire_mode,
    output logic pwm_mode,
    output logic switching,
    output logic limit_reduced,
    output logic [8:0] brightness_code
);
    // ----------------------------------------------------------------
    // Constants at counter width
    // ----------------------------------------------------------------
    localparam logic [17:0] EN_TO = 18'(P_EN_TO_CYC);
    localparam logic [17:0] PWM_TO = 18'(P_PWM_TO_CYC);
    localparam logic [17:0] SS_LEN = 18'(P_SS_CYC);
    localparam logic [17:0] WIN = 18'(P_DET_WIN_CYC);
    localparam logic [17:0] ACK_LEN = 18'(P_ACK_LEN_CYC);
    localparam logic [17:0] DLY = 18'(`ODC_DET_DLY_CYC);
    localparam logic [17:0] DET_LO = 18'(`ODC_DET_LO_CYC);
    localparam logic [17:0] BIT_MAX = 18'(`ODC_BIT_MAX_CYC);
    localparam logic [17:0] ACK_VAL = 18'(`ODC_ACK_VAL_CYC);
    localparam logic [4:0] LAST_BIT = 5'(`ODC_CMD_BITS - 1);
    // Saturating increment shared by every timer
    function automatic logic [17:0] odc_inc(input logic [17:0] v);
        return (v == 18'h3FFFF) ? v : v + 18'h00001;
    endfunction
    // ----------------------------------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------------------------------
    logic en_s1_r, en_s2_r, en_d_r, pwm_s1_r, pwm_s2_r;
    logic en_fall_w, en_rise_w;
    // Two flops per pin, plus a third on enable for edge detection; only the stages after the first feed logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_s1_r <= 1'b1;
            en_s2_r <= 1'b1;
            en_d_r <= 1'b1;
            pwm_s1_r <= 1'b0;
            pwm_s2_r <= 1'b0;
        end else begin
            en_s1_r <= en_line_i;
            en_s2_r <= en_s1_r;
            en_d_r <= en_s2_r;
            pwm_s1_r <= pwm_i;
            pwm_s2_r <= pwm_s1_r;
        end
    end
    assign en_fall_w = en_d_r & ~en_s2_r;
    assign en_rise_w = ~en_d_r & en_s2_r;
    // ----------------------------------------------------------------
    // Shutdown timeouts and interface selection
    // ----------------------------------------------------------------
    odc_pkg::odc_state_t st_r, st_nxt;
    logic [17:0] en_lo_r, pwm_lo_r, win_r, det_lo_r, ss_r;
    logic shut_w, pattern_w, active_w;
    // Low-time timers; a short blip restarts them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_lo_r <= 18'h00000;
            pwm_lo_r <= 18'h00000;
        end else begin
            en_lo_r <= en_s2_r ? 18'h00000 : odc_inc(en_lo_r);
            pwm_lo_r <= pwm_s2_r ? 18'h00000 : odc_inc(pwm_lo_r);
        end
    end
    // Either pin low too long, or supply lost, forces shutdown
    assign shut_w = ~undervoltage_lockout_ok | (en_lo_r >= EN_TO) | (pwm_lo_r >= PWM_TO);
    // Pattern ends on the rising edge after a long enough late low
    assign pattern_w = en_rise_w & (det_lo_r > DET_LO) & (win_r < WIN);
    assign active_w = (st_r == odc_pkg::ODC_ONEWIRE) | (st_r == odc_pkg::ODC_PWM);
    // Window counter and the low-time that counts only after the delay
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            win_r <= 18'h00000;
            det_lo_r <= 18'h00000;
        end else if (st_r != odc_pkg::ODC_DETECT) begin
            win_r <= 18'h00000;
            det_lo_r <= 18'h00000;
        end else begin
            win_r <= odc_inc(win_r);
            det_lo_r <= (en_s2_r || win_r < DLY) ? 18'h00000 : odc_inc(det_lo_r);
        end
    end
    // Mode state machine; shutdown clears any earlier selection
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            odc_pkg::ODC_SHUT: begin
                if (undervoltage_lockout_ok && pwm_s2_r && en_rise_w) begin
                    st_nxt = odc_pkg::ODC_DETECT;
                end
            end
            odc_pkg::ODC_DETECT: begin
                if (shut_w) begin
                    st_nxt = odc_pkg::ODC_SHUT;
                end else if (pattern_w) begin
                    st_nxt = odc_pkg::ODC_ONEWIRE;
                end else if (win_r >= WIN) begin
                    st_nxt = odc_pkg::ODC_PWM;
                end
            end
            odc_pkg::ODC_ONEWIRE, odc_pkg::ODC_PWM: begin
                if (shut_w) begin
                    st_nxt = odc_pkg::ODC_SHUT;
                end
            end
            default: st_nxt = odc_pkg::ODC_SHUT;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= odc_pkg::ODC_SHUT;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ----------------------------------------------------------------
    // Soft-start current limit timer
    // ----------------------------------------------------------------
    // Starts once the interface is settled, i.e. after detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ss_r <= 18'h00000;
        end else begin
            ss_r <= active_w ? odc_inc(ss_r) : 18'h00000;
        end
    end
    // ----------------------------------------------------------------
    // One-wire receiver
    // ----------------------------------------------------------------
    odc_pkg::odc_ack_t ack_r;
    logic [17:0] lo_r, hi_r, ack_cnt_r;
    logic [23:0] sh_r;
    logic [4:0] cnt_r;
    logic busy_r, err_r, ack_allow_r;
    logic rx_fall_w, dec_val_w, dec_ok_w, done_w, good_w, abort_w;
    logic [23:0] word_w;
    // Own pull on the line must not be taken for host traffic
    assign rx_fall_w = (st_r == odc_pkg::ODC_ONEWIRE) & (ack_r == odc_pkg::ODC_ACK_IDLE) & en_fall_w;
    // Ratio decode needs no rate setting
    assign dec_val_w = ({1'b0, hi_r} >= {lo_r, 1'b0});
    assign dec_ok_w = dec_val_w | ({1'b0, lo_r} >= {hi_r, 1'b0});
    // Shift in from the top so the first bit lands at bit 0
    assign word_w = {dec_val_w, sh_r[23:1]};
    // The falling edge closing bit 23 ends the command
    assign done_w = rx_fall_w & busy_r & (cnt_r == LAST_BIT);
    // Address checked; bits 15..11 and 9 play no part
    assign good_w = done_w & ~err_r & dec_ok_w & (word_w[23:16] == P_DEV_ADDR);
    // A level held past the longest bit half means the stream broke off
    assign abort_w = busy_r & ~rx_fall_w & ((lo_r > BIT_MAX) | (hi_r > BIT_MAX));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            err_r <= 1'b0;
            cnt_r <= 5'h00;
            sh_r <= 24'h000000;
            lo_r <= 18'h00000;
            hi_r <= 18'h00000;
        end else if (st_r != odc_pkg::ODC_ONEWIRE || abort_w) begin
            busy_r <= 1'b0;
            lo_r <= 18'h00000;
            hi_r <= 18'h00000;
        end else if (rx_fall_w) begin
            busy_r <= ~done_w;
            err_r <= busy_r & (err_r | ~dec_ok_w);
            cnt_r <= busy_r ? cnt_r + 5'h01 : 5'h00;
            sh_r <= busy_r ? word_w : sh_r;
            lo_r <= 18'h00000;
            hi_r <= 18'h00000;
        end else if (busy_r) begin
            lo_r <= en_s2_r ? lo_r : odc_inc(lo_r);
            hi_r <= en_s2_r ? odc_inc(hi_r) : hi_r;
        end
    end
    // Acknowledge: wait the valid delay, then pull low for a fixed time
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= odc_pkg::ODC_ACK_IDLE;
            ack_cnt_r <= 18'h00000;
        end else begin
            ack_cnt_r <= odc_inc(ack_cnt_r);
            case (ack_r)
                odc_pkg::ODC_ACK_IDLE: begin
                    ack_cnt_r <= 18'h00000;
                    if (good_w && word_w[`ODC_ACK_BIT] && ack_allow_r) begin
                        ack_r <= odc_pkg::ODC_ACK_WAIT;
                    end
                end
                odc_pkg::ODC_ACK_WAIT: begin
                    if (ack_cnt_r >= ACK_VAL - 18'h00001) begin
                        ack_r <= odc_pkg::ODC_ACK_PULL;
                        ack_cnt_r <= 18'h00000;
                    end
                end
                odc_pkg::ODC_ACK_PULL: begin
                    if (ack_cnt_r >= ACK_LEN - 18'h00001 || st_r != odc_pkg::ODC_ONEWIRE) begin
                        ack_r <= odc_pkg::ODC_ACK_IDLE;
                    end
                end
                default: ack_r <= odc_pkg::ODC_ACK_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Register port and outputs
    // ----------------------------------------------------------------
    logic [15:0] status_w, rd_w;
    assign status_w = {2'h0, ack_r == odc_pkg::ODC_ACK_PULL, limit_reduced, dev_on,
                       pwm_mode, onewire_mode, brightness_code};
    assign rd_w = (reg_addr == `ODC_REG_STATUS) ? status_w :
                  (reg_addr == `ODC_REG_CTRL) ? {15'h0000, ack_allow_r} : 16'h0000;
    // Read data stand one cycle after the strobe only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            ack_allow_r <= 1'(`ODC_CTRL_RST);
        end else begin
            reg_rdata <= reg_rd ? rd_w : 16'h0000;
            if (reg_wr && reg_addr == `ODC_REG_CTRL) begin
                ack_allow_r <= reg_wdata[0];
            end
        end
    end
    // Code defaults on any shutdown; current is full scale times code/511
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brightness_code <= `ODC_CODE_DEF;
        end else if (st_r == odc_pkg::ODC_SHUT) begin
            brightness_code <= `ODC_CODE_DEF;
        end else if (good_w) begin
            brightness_code <= word_w[8:0];
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dev_on <= 1'b0;
            onewire_mode <= 1'b0;
            pwm_mode <= 1'b0;
            switching <= 1'b0;
            limit_reduced <= 1'b0;
            line_pull_o <= 1'b0;
            line_pull_oe <= 1'b0;
        end else begin
            dev_on <= (st_r != odc_pkg::ODC_SHUT);
            onewire_mode <= (st_r == odc_pkg::ODC_ONEWIRE);
            pwm_mode <= (st_r == odc_pkg::ODC_PWM);
            switching <= active_w;
            limit_reduced <= active_w & (ss_r < SS_LEN);
            line_pull_o <= 1'b0;
            line_pull_oe <= (ack_r == odc_pkg::ODC_ACK_PULL);
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_en_timeout;
        @(posedge ref_clk) disable iff (rst)
        (en_lo_r >= EN_TO && st_r != odc_pkg::ODC_SHUT) |=> st_r == odc_pkg::ODC_SHUT;
    endproperty
    a_en_timeout: assert property (p_en_timeout) else $error("enable timeout missed");
    property p_limit;
        @(posedge ref_clk) disable iff (rst)
        $rose(switching) |-> limit_reduced ##1 limit_reduced[*3];
    endproperty
    a_limit: assert property (p_limit) else $error("start limit not held");
    property p_wake;
        @(posedge ref_clk) disable iff (rst)
        (st_r == odc_pkg::ODC_SHUT && undervoltage_lockout_ok && pwm_s2_r && en_rise_w) |=> st_r == odc_pkg::ODC_DETECT;
    endproperty
    a_wake: assert property (p_wake) else $error("no detection after wake");
    property p_select;
        @(posedge ref_clk) disable iff (rst)
        (st_r == odc_pkg::ODC_DETECT ##1 st_r == odc_pkg::ODC_ONEWIRE) |->
            $past(det_lo_r) > DET_LO && $past(win_r) < WIN;
    endproperty
    a_select: assert property (p_select) else $error("one-wire without pattern");
    property p_fallback;
        @(posedge ref_clk) disable iff (rst)
        (st_r == odc_pkg::ODC_DETECT && win_r >= WIN && !pattern_w && !shut_w) |=>
            st_r == odc_pkg::ODC_PWM;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no pwm fallback");
    property p_default;
        @(posedge ref_clk) disable iff (rst)
        st_r == odc_pkg::ODC_SHUT |=> brightness_code == `ODC_CODE_DEF;
    endproperty
    a_default: assert property (p_default) else $error("code not defaulted");
    property p_store;
        @(posedge ref_clk) disable iff (rst)
        good_w |=> brightness_code == $past(word_w[8:0]) && $past(word_w[23:16]) == P_DEV_ADDR;
    endproperty
    a_store: assert property (p_store) else $error("code not stored");
    property p_keep;
        @(posedge ref_clk) disable iff (rst)
        (abort_w || (done_w && !good_w)) && st_r != odc_pkg::ODC_SHUT |=> $stable(brightness_code);
    endproperty
    a_keep: assert property (p_keep) else $error("dropped command changed code");
    property p_ack_cause;
        @(posedge ref_clk) disable iff (rst)
        $rose(line_pull_oe) |-> $past(ack_r, 2) == odc_pkg::ODC_ACK_WAIT;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_len;
        @(posedge ref_clk) disable iff (rst)
        ack_r == odc_pkg::ODC_ACK_PULL |-> ack_cnt_r < ACK_LEN;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too long");
    c_onewire: cover property (@(posedge ref_clk) disable iff (rst) st_r == odc_pkg::ODC_ONEWIRE);
    c_pwm: cover property (@(posedge ref_clk) disable iff (rst) st_r == odc_pkg::ODC_PWM);
    c_store: cover property (@(posedge ref_clk) disable iff (rst) good_w);
    c_ack: cover property (@(posedge ref_clk) disable iff (rst) $rose(line_pull_oe));
endmodule

// ===== tb/odc_host.sv
/*
 * Host model on the one-wire enable line: open-drain driver with bit timing.
 * Assumes the bench resolves the line with a pull-up and feeds the device.
 */
module odc_host (
    input wire logic ref_clk,
    output logic host_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Line driver
    // ------------------------------------------------
    // Held low at power-up so the first release is a rising edge
    initial host_low = 1'b1;
    // Level for n cycles from the next edge; released means pulled up
    task automatic drive(input logic lo, input int n);
        @(posedge ref_clk);
        host_low <= lo;
        repeat (n - 1) @(posedge ref_clk);
    endtask
    // n bits, LSB first; s and l are the short and long phase of a bit
    task automatic send(input logic [23:0] cmd, input int n, input int s, input int l);
        drive(1'b0, 40);
        for (int i = 0; i < n; i++) begin
            drive(1'b1, cmd[i] ? s : l);
            drive(1'b0, cmd[i] ? l : s);
        end
        // Last fall, then low over the valid delay before release
        drive(1'b1, 20);
        drive(1'b0, 1);
    endtask
endmodule

// ===== tb/one_wire_dimming_control_test.sv
/*
 * Self-checking bench of odc_top: selection, commands, acknowledge,
 * registers and shutdown, with the host model on the enable line.
 * Assumes shortened timeouts; the enable timeout caps a bit's low phase,
 * so the slowest documented bit rate is not reached here.
 */
module one_wire_dimming_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EN_TO = 3000;
    localparam int PWM_TO = 600;
    localparam int SS = 200;
    localparam int WIN = 5000;
    localparam int ACK_LEN = 100;
    localparam logic [7:0] ADDR = 8'h5A; // Value is arbitrary
    logic ref_clk, rst, undervoltage_lockout_ok, pwm_i, reg_wr, reg_rd, host_low, en_line;
    logic [1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic line_pull_o, line_pull_oe, dev_on, onewire_mode, pwm_mode, switching, limit_reduced;
    logic [8:0] brightness_code;
    int n_errors = 0;
    int cmp_count = 0;
    // ------------------------------------------------
    // Device, host and open-drain line
    // ------------------------------------------------
    // Pull-up: low whenever either party pulls
    assign en_line = ~(host_low | line_pull_oe);
    odc_host u_host (.ref_clk(ref_clk), .host_low(host_low));
    odc_top #(.P_EN_TO_CYC(EN_TO), .P_PWM_TO_CYC(PWM_TO), .P_SS_CYC(SS), .P_DET_WIN_CYC(WIN),
        .P_ACK_LEN_CYC(ACK_LEN), .P_DEV_ADDR(ADDR)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .undervoltage_lockout_ok(undervoltage_lockout_ok), .en_line_i(en_line), .pwm_i(pwm_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_pull_o(line_pull_o), .line_pull_oe(line_pull_oe),
        .dev_on(dev_on), .onewire_mode(onewire_mode), .pwm_mode(pwm_mode), .switching(switching),
        .limit_reduced(limit_reduced), .brightness_code(brightness_code));
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // Counts pull cycles; sampled mid-cycle to stay clear of the edge
    task automatic watch_ack(output int first, output int hi);
        first = -1;
        hi = 0;
        for (int i = 0; i < ACK_LEN + 40; i++) begin
            @(negedge ref_clk);
            if (line_pull_oe === 1'b1) begin
                hi++;
                chk("pull_level", 16'h0000, 16'(line_pull_o));
                if (first < 0) first = i;
            end
        end
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_select();
        u_host.drive(1'b0, 1050);
        @(negedge ref_clk);
        chk("dev_on", 16'h0001, 16'(dev_on));
        chk("modes_window", 16'h0000, {14'h0, onewire_mode, pwm_mode});
        u_host.drive(1'b1, 2700);
        u_host.drive(1'b0, 10);
        @(negedge ref_clk);
        chk("modes", 16'h0005, {13'h0, onewire_mode, pwm_mode, switching});
        chk("limit_on", 16'h0001, 16'(limit_reduced));
        repeat (SS - 30) @(negedge ref_clk);
        chk("limit_late", 16'h0001, 16'(limit_reduced));
        repeat (40) @(negedge ref_clk);
        chk("limit_off", 16'h0000, 16'(limit_reduced));
        chk("code_default", 16'h01FF, 16'(brightness_code));
        $display("select done");
    endtask
    task automatic t_cmds();
        int f, h;
        // Unused bits set on purpose: they must not reach the code
        u_host.send({ADDR, 5'h1F, 1'b0, 1'b1, 9'h0A5}, 24, 30, 70);
        @(negedge ref_clk);
        chk("code", 16'h00A5, 16'(brightness_code));
        u_host.send({ADDR, 7'h00, 9'h15A}, 24, 20, 42);
        @(negedge ref_clk);
        chk("code_fast", 16'h015A, 16'(brightness_code));
        u_host.send({~ADDR, 7'h02, 9'h033}, 24, 30, 70);
        watch_ack(f, h);
        chk("ack_bad_addr", 16'h0000, 16'(h));
        chk("code_bad_addr", 16'h015A, 16'(brightness_code));
        u_host.send({ADDR, 7'h00, 9'h033}, 23, 30, 70);
        repeat (3700) @(negedge ref_clk);
        chk("code_short", 16'h015A, 16'(brightness_code));
        u_host.send({ADDR, 7'h00, 9'h033}, 24, 50, 50);
        repeat (3700) @(negedge ref_clk);
        chk("code_bad_ratio", 16'h015A, 16'(brightness_code));
        $display("commands done");
    endtask
    task automatic t_ack();
        int f, h;
        logic [15:0] d;
        u_host.send({ADDR, 7'h02, 9'h155}, 24, 90, 270);
        watch_ack(f, h);
        chk("code_ack", 16'h0155, 16'(brightness_code));
        chk("ack_start", 16'h0001, 16'(f >= 0 && f <= 8));
        chk("ack_len", 16'(ACK_LEN), 16'(h));
        reg_read(2'h0, d);
        chk("status", 16'h0B55, d);
        reg_write(2'h0, 16'hFFFF);
        reg_read(2'h0, d);
        chk("status_ro", 16'h0B55, d);
        reg_read(2'h3, d);
        chk("unmapped", 16'h0000, d);
        reg_read(2'h1, d);
        chk("ctrl_reset", 16'h0001, d);
        reg_write(2'h1, 16'h0000);
        u_host.send({ADDR, 7'h02, 9'h0F0}, 24, 30, 70);
        watch_ack(f, h);
        chk("ack_masked", 16'h0000, 16'(h));
        chk("code_masked", 16'h00F0, 16'(brightness_code));
        reg_write(2'h1, 16'h0001);
        $display("acknowledge done");
    endtask
    task automatic t_shut();
        u_host.drive(1'b1, 2900);
        @(negedge ref_clk);
        chk("on_en_low", 16'h0001, 16'(dev_on));
        u_host.drive(1'b1, 200);
        @(negedge ref_clk);
        chk("off_en", 16'h0000, {14'h0, dev_on, onewire_mode});
        chk("code_reset", 16'h01FF, 16'(brightness_code));
        u_host.drive(1'b0, WIN + 100);
        @(negedge ref_clk);
        chk("modes_pwm", 16'h0003, {13'h0, onewire_mode, pwm_mode, switching});
        u_host.send({ADDR, 7'h00, 9'h011}, 24, 30, 70);
        @(negedge ref_clk);
        chk("code_pwm", 16'h01FF, 16'(brightness_code));
        @(posedge ref_clk);
        pwm_i <= 1'b0;
        repeat (PWM_TO - 50) @(negedge ref_clk);
        chk("on_pwm_low", 16'h0001, 16'(dev_on));
        repeat (100) @(negedge ref_clk);
        chk("off_pwm", 16'h0000, 16'(dev_on));
        u_host.drive(1'b1, 20);
        u_host.drive(1'b0, 50);
        @(negedge ref_clk);
        chk("stay_off", 16'h0000, 16'(dev_on));
        $display("shutdown done");
    endtask
    // ------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Dimming pin held high while the one-wire link is in use
    initial begin
        rst = 1'b1;
        undervoltage_lockout_ok = 1'b1;
        pwm_i = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_select();
        t_cmds();
        t_ack();
        t_shut();
        give_verdict();
    end
    initial begin
        repeat (95000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule
